// file: logic/port_regs_map.svh
`ifndef PORT_REGS_MAP_SVH
`define PORT_REGS_MAP_SVH

// Register indices within one port page; byte address is four times the index
`define OFS_TREE_POINTER 12'hb01
`define OFS_TREE_STATE 12'hb04
`define OFS_RX_LATENCY 12'hc00
`define OFS_TX_LATENCY 12'hc02
`define OFS_ASYMMETRY 12'hc04
`define OFS_DREQ_HIGH 12'hc08
`define OFS_DREQ_LOW 12'hc0a
`define OFS_SYNC_HIGH 12'hc0c
`define OFS_SYNC_LOW 12'hc0e
`define OFS_PDRESP_HIGH 12'hc10
`define OFS_PDRESP_LOW 12'hc12
`define OFS_STAMP_STATUS 12'hc14

// Tree-state entry fields
`define TREE_TX_BIT 2
`define TREE_RX_BIT 1
`define TREE_NOLEARN_BIT 0
`define TREE_STATE_RST 3'b110

// Asymmetry fields
`define ASYM_SIGN_BIT 15

// Stamp status flag positions
`define FLAG_SYNC_BIT 15
`define FLAG_DREQ_BIT 14
`define FLAG_PDRESP_BIT 13

// Reset values
`define RX_LATENCY_RST 16'h019f
`define TX_LATENCY_RST 16'h002d
`define ASYMMETRY_RST 16'h0000
`define STAMP_RST 32'h0000_0000

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: logic/port_regs_pkg.sv
package port_regs_pkg;
   // Kind of timing frame seen by the datapath
   typedef enum logic [1:0] {
      KIND_SYNC,
      KIND_DELAY_REQ,
      KIND_PDELAY_REQ,
      KIND_PDELAY_RESP
   } frame_kind_e;

   // Write side progress of the bus slave
   typedef enum logic [1:0] {
      WR_IDLE,
      WR_REFRESH,
      WR_RESP
   } wr_state_e;

   // Three-bit tree-state entry
   typedef logic [2:0] tree_entry_t;
endpackage

// file: logic/tree_mem_if.sv
interface tree_mem_if #(parameter int ADDR_W = 6);
   import port_regs_pkg::*;
   logic we; // Write strobe
   logic [ADDR_W-1:0] waddr; // Write entry
   port_regs_pkg::tree_entry_t wdata; // Write value
   logic re; // Read strobe
   logic [ADDR_W-1:0] raddr; // Read entry
   port_regs_pkg::tree_entry_t rdata; // Registered read value
   modport owner (output we, waddr, wdata, re, raddr, input rdata);
   modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// file: logic/tree_state_mem.sv
`include "port_regs_map.svh"
module tree_state_mem #(
   parameter int DEPTH = 56,
   parameter int ADDR_W = 6
) (
   input wire logic ref_clk,
   input wire logic rstn,
   tree_mem_if.store mem
);
   import port_regs_pkg::*;

   // Whole state: the entries and the registered read word
   typedef struct packed {
      logic [DEPTH-1:0][2:0] entry;
      logic [2:0] rdata;
   } mem_state_s;

   mem_state_s q;
   mem_state_s next_q;

   assign mem.rdata = q.rdata;

   // Write an entry and register the addressed read word
   always_comb begin
      next_q = q;
      if (mem.we && (int'(mem.waddr) < DEPTH)) begin
         next_q.entry[mem.waddr] = mem.wdata;
      end
      if (mem.re && (int'(mem.raddr) < DEPTH)) begin
         next_q.rdata = q.entry[mem.raddr];
      end
   end

   // Every entry starts with transmit and receive on, learning on
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         q.entry <= {DEPTH{`TREE_STATE_RST}};
         q.rdata <= `TREE_STATE_RST;
      end else begin
         q <= next_q;
      end
   end
endmodule

// file: logic/port_regs.sv
`include "port_regs_map.svh"
module port_regs #(
   parameter int PORTS = 7,
   parameter int AW = 18
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cap_valid,
   input wire logic [2:0] cap_port,
   input wire port_regs_pkg::frame_kind_e cap_kind,
   input wire logic [31:0] cap_time,
   input wire logic corr_req,
   input wire logic [2:0] corr_port,
   input wire port_regs_pkg::frame_kind_e corr_kind,
   output logic corr_valid,
   output logic [16:0] corr_delta,
   output logic [PORTS-1:0] tx_enable,
   output logic [PORTS-1:0] rx_enable,
   output logic [PORTS-1:0] learn_disable
);
   import port_regs_pkg::*;

   // Whole state of the bank and its bus slave
   typedef struct packed {
      wr_state_e wr_st;
      logic aw_held; // Write address taken
      logic w_held; // Write data taken
      logic [15:0] widx; // Held write index
      logic [31:0] wdata; // Held write data
      logic [3:0] wstrb; // Held byte enables
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] ridx; // Index of the last read
      logic [PORTS-1:0][2:0] ptr; // Tree-instance pointers
      logic [PORTS-1:0][2:0] shadow; // Copy of each selected entry
      logic [PORTS-1:0][15:0] rx_lat;
      logic [PORTS-1:0][15:0] tx_lat;
      logic [PORTS-1:0][15:0] asym;
      logic [PORTS-1:0][31:0] dreq_ts;
      logic [PORTS-1:0][31:0] sync_egress_stamp;
      logic [PORTS-1:0][31:0] pdresp_ts;
      logic [PORTS-1:0][2:0] flags; // Sync, request, response
      logic [2:0] refresh_port; // Port whose shadow awaits memory
      logic corr_valid;
      logic [16:0] corr_delta;
   } bank_state_s;

   bank_state_s q;
   bank_state_s next_q;

   tree_mem_if #(.ADDR_W(6)) mem ();

   tree_state_mem #(.DEPTH(PORTS * 8), .ADDR_W(6)) u_tree_mem (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .mem(mem)
   );

   // Port field of an index: 1..PORTS is mapped, else no hit
   function automatic logic port_ok(input logic [15:0] idx);
      port_ok = (idx[15:12] != 4'h0) && (int'(idx[15:12]) <= PORTS);
   endfunction

   // Read decode of one register word
   function automatic logic [32:0] read_word(input bank_state_s s, input logic [15:0] idx);
      logic [2:0] p;
      logic [32:0] r;
      p = 3'(idx[14:12] - 3'h1);
      r = {1'b0, 32'h0000_0000};
      if (port_ok(idx)) begin
         r[32] = 1'b1;
         case (idx[11:0])
            `OFS_TREE_POINTER: r[2:0] = s.ptr[p];
            `OFS_TREE_STATE: r[2:0] = s.shadow[p];
            `OFS_RX_LATENCY: r[15:0] = s.rx_lat[p];
            `OFS_TX_LATENCY: r[15:0] = s.tx_lat[p];
            `OFS_ASYMMETRY: r[15:0] = s.asym[p];
            `OFS_DREQ_HIGH: r[15:0] = s.dreq_ts[p][31:16];
            `OFS_DREQ_LOW: r[15:0] = s.dreq_ts[p][15:0];
            `OFS_SYNC_HIGH: r[15:0] = s.sync_egress_stamp[p][31:16];
            `OFS_SYNC_LOW: r[15:0] = s.sync_egress_stamp[p][15:0];
            `OFS_PDRESP_HIGH: r[15:0] = s.pdresp_ts[p][31:16];
            `OFS_PDRESP_LOW: r[15:0] = s.pdresp_ts[p][15:0];
            `OFS_STAMP_STATUS: r[15:13] = s.flags[p];
            default: r[32] = 1'b0;
         endcase
      end
      read_word = r;
   endfunction

   // Bus slave, register writes, captures and correction lookup
   always_comb begin
      logic [2:0] p;
      logic [32:0] rw;
      logic [16:0] value;
      logic hit;
      logic [2:0] cp;
      logic [2:0] setm; // Flags raised by a capture this cycle
      p = 3'(q.widx[14:12] - 3'h1);
      setm = 3'h0;
      rw = 33'h0;
      value = 17'h0;
      hit = 1'b0;
      cp = 3'(cap_port - 3'h1);
      next_q = q;
      mem.we = 1'b0;
      mem.waddr = {p, q.ptr[p]};
      mem.wdata = q.wdata[2:0];
      mem.re = 1'b0;
      mem.raddr = {p, q.wdata[2:0]};
      // Egress captures load both words at once and raise the flag
      if (cap_valid && (cap_port != 3'h0) && (int'(cap_port) <= PORTS)) begin
         case (cap_kind)
            KIND_SYNC: begin
               next_q.sync_egress_stamp[cp] = cap_time;
               next_q.flags[cp][2] = 1'b1;
               setm[2] = 1'b1;
            end
            KIND_DELAY_REQ, KIND_PDELAY_REQ: begin
               next_q.dreq_ts[cp] = cap_time;
               next_q.flags[cp][1] = 1'b1;
               setm[1] = 1'b1;
            end
            KIND_PDELAY_RESP: begin
               next_q.pdresp_ts[cp] = cap_time;
               next_q.flags[cp][0] = 1'b1;
               setm[0] = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // Address and data are taken in either order
      if (s_axi_awvalid && !q.aw_held && q.wr_st == WR_IDLE) begin
         next_q.aw_held = 1'b1;
         next_q.widx = s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && !q.w_held && q.wr_st == WR_IDLE) begin
         next_q.w_held = 1'b1;
         next_q.wdata = s_axi_wdata;
         next_q.wstrb = s_axi_wstrb;
      end
      case (q.wr_st)
         WR_IDLE: begin
            if (q.aw_held && q.w_held) begin
               next_q.aw_held = 1'b0;
               next_q.w_held = 1'b0;
               next_q.bvalid = 1'b1;
               next_q.wr_st = WR_RESP;
               rw = read_word(q, q.widx);
               hit = rw[32];
               next_q.bresp = hit ? `RESP_OKAY : `RESP_SLVERR;
               if (hit) begin
                  case (q.widx[11:0])
                     `OFS_TREE_POINTER: begin
                        if (q.wstrb[0]) begin
                           next_q.ptr[p] = q.wdata[2:0];
                           mem.re = 1'b1;
                           next_q.refresh_port = p;
                           next_q.bvalid = 1'b0;
                           next_q.wr_st = WR_REFRESH;
                        end
                     end
                     `OFS_TREE_STATE: begin
                        if (q.wstrb[0]) begin
                           mem.we = 1'b1;
                           next_q.shadow[p] = q.wdata[2:0];
                        end
                     end
                     `OFS_RX_LATENCY: begin
                        if (q.wstrb[0]) next_q.rx_lat[p][7:0] = q.wdata[7:0];
                        if (q.wstrb[1]) next_q.rx_lat[p][15:8] = q.wdata[15:8];
                     end
                     `OFS_TX_LATENCY: begin
                        if (q.wstrb[0]) next_q.tx_lat[p][7:0] = q.wdata[7:0];
                        if (q.wstrb[1]) next_q.tx_lat[p][15:8] = q.wdata[15:8];
                     end
                     `OFS_ASYMMETRY: begin
                        if (q.wstrb[0]) next_q.asym[p][7:0] = q.wdata[7:0];
                        if (q.wstrb[1]) next_q.asym[p][15:8] = q.wdata[15:8];
                     end
                     `OFS_STAMP_STATUS: begin
                        // Write one clears; a capture this cycle wins
                        if (q.wstrb[1]) begin
                           // A flag raised by a capture this cycle survives the clear
                           next_q.flags[p] = next_q.flags[p]
                              & ~(q.wdata[15:13] & ~((cp == p) ? setm : 3'h0));
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end
         WR_REFRESH: begin
            // Newly selected entry arrives from the store
            next_q.shadow[q.refresh_port] = mem.rdata;
            next_q.bvalid = 1'b1;
            next_q.wr_st = WR_RESP;
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               next_q.bvalid = 1'b0;
               next_q.wr_st = WR_IDLE;
            end
         end
         default: next_q.wr_st = WR_IDLE;
      endcase
      // Read answer follows the address by one cycle
      if (q.rvalid && s_axi_rready) begin
         next_q.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !q.rvalid) begin
         rw = read_word(q, s_axi_araddr[17:2]);
         next_q.rvalid = 1'b1;
         next_q.ridx = s_axi_araddr[17:2];
         next_q.rdata = rw[31:0];
         next_q.rresp = rw[32] ? `RESP_OKAY : `RESP_SLVERR;
      end
      // Signed correction: KIND_SYNC and KIND_PDELAY_RESP add the asymmetry, the two request kinds subtract it
      next_q.corr_valid = corr_req;
      next_q.corr_delta = 17'h0;
      if (corr_req && (corr_port != 3'h0) && (int'(corr_port) <= PORTS)) begin
         value = {2'b00, q.asym[3'(corr_port - 3'h1)][14:0]};
         if (q.asym[3'(corr_port - 3'h1)][`ASYM_SIGN_BIT]) value = 17'(-value);
         case (corr_kind)
            KIND_SYNC, KIND_PDELAY_RESP: next_q.corr_delta = value;
            default: next_q.corr_delta = 17'(-value);
         endcase
      end
   end

   // State register with documented reset values
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         q <= '0;
         q.wr_st <= WR_IDLE;
         q.shadow <= {PORTS{`TREE_STATE_RST}};
         q.rx_lat <= {PORTS{`RX_LATENCY_RST}};
         q.tx_lat <= {PORTS{`TX_LATENCY_RST}};
         q.asym <= {PORTS{`ASYMMETRY_RST}};
      end else begin
         q <= next_q;
      end
   end

   // Outputs straight from the state flops
   assign s_axi_awready = !q.aw_held && (q.wr_st == WR_IDLE);
   assign s_axi_wready = !q.w_held && (q.wr_st == WR_IDLE);
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign corr_valid = q.corr_valid;
   assign corr_delta = q.corr_delta;

   // Per-port gating from the selected entry
   always_comb begin
      for (int i = 0; i < PORTS; i++) begin
         tx_enable[i] = q.shadow[i][`TREE_TX_BIT];
         rx_enable[i] = q.shadow[i][`TREE_RX_BIT];
         learn_disable[i] = q.shadow[i][`TREE_NOLEARN_BIT];
      end
   end

   AST_RESET_VALUES: assert property (@(posedge ref_clk) disable iff (!rstn)
      !$past(rstn) |-> tx_enable == 7'h7f && rx_enable == 7'h7f && learn_disable == 7'h00
         && q.rx_lat[0] == 16'h019f && q.tx_lat[0] == 16'h002d)
      else $error("Reset values wrong");
   AST_SYNC_PAIR: assert property (@(posedge ref_clk) disable iff (!rstn)
      cap_valid && cap_kind == KIND_SYNC && cap_port == 3'h1 |=> q.sync_egress_stamp[0] == $past(cap_time))
      else $error("Sync stamp words not loaded together");
   AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
      cap_valid && cap_kind == KIND_PDELAY_RESP && cap_port == 3'h2 |=> q.flags[1][0])
      else $error("Capture flag not set");
   AST_PTR_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
      q.wr_st == WR_IDLE && q.aw_held && q.w_held && q.wstrb[0]
         && q.widx == 16'h1b01 |=> q.ptr[0] == $past(q.wdata[2:0]) ##1 s_axi_bvalid)
      else $error("Pointer write or refresh wrong");
   AST_TREE_RESERVED: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_axi_rvalid && q.ridx[11:0] == 12'hb04 |-> s_axi_rdata[31:3] == 29'h0)
      else $error("Tree-state reserved bits not zero");
   AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr[17:14] == 4'h0
         |=> s_axi_rvalid && s_axi_rresp == 2'h2)
      else $error("Port zero read not refused");
   AST_CORR_SIGN: assert property (@(posedge ref_clk) disable iff (!rstn)
      corr_req && corr_port == 3'h1 && corr_kind == KIND_DELAY_REQ && q.asym[0] == 16'h0005
         |=> corr_valid && corr_delta == 17'h1fffb)
      else $error("Egress correction not subtracted");
   AST_ASYM_NEG: assert property (@(posedge ref_clk) disable iff (!rstn)
      corr_req && corr_port == 3'h1 && corr_kind == KIND_SYNC && q.asym[0] == 16'h8003
         |=> corr_delta == 17'h1fffd)
      else $error("Negative asymmetry wrong");
   AST_BRESP_BOUND: assert property (@(posedge ref_clk) disable iff (!rstn)
      q.wr_st == WR_IDLE && q.aw_held && q.w_held |-> ##[1:2] s_axi_bvalid)
      else $error("Write answer late");
endmodule

// file: tb/port_regs_bench.sv
`include "port_regs_map.svh"
module port_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import port_regs_pkg::*;
   logic ref_clk, rstn; // Clock and synchronous reset
   logic [17:0] awaddr, araddr; // Byte addresses
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata; // Bus data
   logic [3:0] wstrb; // Byte lanes
   logic [1:0] bresp, rresp; // Bus answers
   logic cap_valid, corr_req, corr_valid; // Capture and correction strobes
   logic [2:0] cap_port, corr_port; // Port numbers
   frame_kind_e cap_kind, corr_kind; // Frame kinds
   logic [31:0] cap_time; // Stamp value
   logic [16:0] corr_delta; // Correction answer
   logic [6:0] tx_enable, rx_enable, learn_disable; // Tree state outputs
   logic [33:0] bus_q[$]; // Noted bus answers {resp, data}
   logic [16:0] corr_q[$]; // Noted correction answers
   integer miscompares = 0, checks = 0, cycles = 0, seed = 32'hd88e;
   logic [2:0] tv[8]; // Written tree entries
   logic [15:0] asym; // Written asymmetry
   logic [31:0] t; // Stamp under test
   logic [16:0] sv; // Signed asymmetry
   int pt; // Port under test

   port_regs #(.PORTS(7), .AW(18)) dut (.ref_clk(ref_clk), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cap_valid(cap_valid), .cap_port(cap_port), .cap_kind(cap_kind), .cap_time(cap_time),
      .corr_req(corr_req), .corr_port(corr_port), .corr_kind(corr_kind),
      .corr_valid(corr_valid), .corr_delta(corr_delta), .tx_enable(tx_enable),
      .rx_enable(rx_enable), .learn_disable(learn_disable));

   // Free-running clock, 100 MHz
   always #5 ref_clk = ~ref_clk;

   // Prints the verdict and ends the run
   task wrap_up;
      $display("Counts: checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Compares one observed value with its expectation
   task check(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Index of a register in a port page
   function automatic logic [15:0] ix(input int p, input logic [11:0] o);
      return {p[3:0], o};
   endfunction

   // One write: address and data offered together, each released when taken
   task bus_write(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s,
                  input logic [1:0] er);
      logic aw_done, w_done;
      bus_q.push_back({er, 32'h0});
      awaddr <= {idx, 2'b00};
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
         @(posedge ref_clk);
         if (awvalid && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // Hold bready until the answer is sampled
      do @(posedge ref_clk); while (!bvalid);
      bready <= 1'b0;
      // One edge passes so a following call does not raise bready in the same step
      @(posedge ref_clk);
   endtask

   // One read; the monitor compares the answer with the note
   task bus_read(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
      logic ar_done;
      bus_q.push_back({er, ed});
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      ar_done = 1'b0;
      do begin
         @(posedge ref_clk);
         if (!ar_done && arvalid && arready) begin
            ar_done = 1'b1;
            arvalid <= 1'b0;
         end
      end while (!(ar_done && rvalid));
      rready <= 1'b0;
      // One edge passes so a following call does not raise rready in the same step
      @(posedge ref_clk);
   endtask

   // One-cycle egress capture pulse
   task capture(input int p, input int k, input logic [31:0] tm);
      cap_valid <= 1'b1;
      cap_port <= p[2:0];
      cap_kind <= frame_kind_e'(k);
      cap_time <= tm;
      @(posedge ref_clk);
      cap_valid <= 1'b0;
      @(posedge ref_clk);
   endtask

   // One-cycle correction request with its noted answer
   task correct(input int p, input int k, input logic [16:0] ed);
      corr_q.push_back(ed);
      corr_req <= 1'b1;
      corr_port <= p[2:0];
      corr_kind <= frame_kind_e'(k);
      @(posedge ref_clk);
      corr_req <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Watches the outputs and takes the oldest note for each answer
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up;
      end
      if (rstn && rvalid && rready) begin
         if (bus_q.size() == 0) miscompares++;
         else check({rresp, rdata}, bus_q.pop_front());
      end
      if (rstn && bvalid && bready) begin
         if (bus_q.size() == 0) miscompares++;
         else check({bresp, 32'h0}, bus_q.pop_front());
      end
      if (rstn && corr_valid) begin
         if (corr_q.size() == 0) miscompares++;
         else check({17'h0, corr_delta}, {17'h0, corr_q.pop_front()});
      end
   end

   // Main sequence
   initial begin
      ref_clk = 0; rstn = 0; awaddr = 0; araddr = 0; awvalid = 0; wvalid = 0; bready = 0;
      arvalid = 0; rready = 0; wdata = 0; wstrb = 0; cap_valid = 0; cap_port = 0;
      cap_kind = KIND_SYNC; cap_time = 0; corr_req = 0; corr_port = 0; corr_kind = KIND_SYNC;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      // Reset values of every port page
      for (int p = 1; p <= 7; p++) begin
         bus_read(ix(p, `OFS_TREE_POINTER), 32'h0, `RESP_OKAY);
         bus_read(ix(p, `OFS_TREE_STATE), 32'h6, `RESP_OKAY);
         bus_read(ix(p, `OFS_RX_LATENCY), 32'h019f, `RESP_OKAY);
         bus_read(ix(p, `OFS_TX_LATENCY), 32'h002d, `RESP_OKAY);
         bus_read(ix(p, `OFS_ASYMMETRY), 32'h0, `RESP_OKAY);
         for (logic [11:0] o = `OFS_DREQ_HIGH; o <= `OFS_PDRESP_LOW; o += 12'h002)
            bus_read(ix(p, o), 32'h0, `RESP_OKAY);
      end
      check({27'h0, tx_enable}, 34'h7f);
      check({27'h0, learn_disable}, 34'h0);
      $display("test reset_values finished");
      // Eight tree entries behind the pointer, reserved bits dropped
      pt = 1 + ($unsigned($random(seed)) % 7);
      for (int e = 0; e < 8; e++) begin
         tv[e] = $random(seed);
         bus_write(ix(pt, `OFS_TREE_POINTER), e, 4'h1, `RESP_OKAY);
         bus_write(ix(pt, `OFS_TREE_STATE), $random(seed) & 32'hf8 | tv[e],
                   4'h1, `RESP_OKAY);
      end
      for (int e = 7; e >= 0; e--) begin
         bus_write(ix(pt, `OFS_TREE_POINTER), e, 4'h1, `RESP_OKAY);
         bus_read(ix(pt, `OFS_TREE_STATE), {29'h0, tv[e]}, `RESP_OKAY);
         check({33'h0, tx_enable[pt-1]}, {33'h0, tv[e][2]});
         check({33'h0, rx_enable[pt-1]}, {33'h0, tv[e][1]});
         check({33'h0, learn_disable[pt-1]}, {33'h0, tv[e][0]});
      end
      check({27'h0, tx_enable | (7'h1 << (pt - 1))}, 34'h7f);
      bus_write(ix(1, `OFS_TREE_POINTER), 32'h3, 4'h1, `RESP_OKAY);
      bus_read(ix(1, `OFS_TREE_POINTER), 32'h3, `RESP_OKAY);
      $display("test tree_state finished");
      // Latency registers keep what was written
      for (int p = 1; p <= 7; p++) begin
         t = $random(seed);
         bus_write(ix(p, `OFS_RX_LATENCY), t, 4'h3, `RESP_OKAY);
         bus_write(ix(p, `OFS_TX_LATENCY), ~t, 4'h3, `RESP_OKAY);
         bus_read(ix(p, `OFS_RX_LATENCY), {16'h0, t[15:0]}, `RESP_OKAY);
         bus_read(ix(p, `OFS_TX_LATENCY), {16'h0, ~t[15:0]}, `RESP_OKAY);
      end
      $display("test latency finished");
      // Captures of every frame kind, flags set and cleared
      for (int k = 0; k < 4; k++) begin
         // Sync on port 1 and response on port 2 reach the design's assertions
         pt = (k == 0) ? 1 : (k == 3) ? 2 : 1 + ($unsigned($random(seed)) % 7);
         t = $random(seed);
         capture(pt, k, t);
         if (k == 0) begin
            bus_read(ix(pt, `OFS_SYNC_HIGH), {16'h0, t[31:16]}, `RESP_OKAY);
            bus_read(ix(pt, `OFS_SYNC_LOW), {16'h0, t[15:0]}, `RESP_OKAY);
            bus_read(ix(pt, `OFS_STAMP_STATUS), 32'h8000, `RESP_OKAY);
         end else if (k == 3) begin
            bus_read(ix(pt, `OFS_PDRESP_HIGH), {16'h0, t[31:16]}, `RESP_OKAY);
            bus_read(ix(pt, `OFS_PDRESP_LOW), {16'h0, t[15:0]}, `RESP_OKAY);
            bus_read(ix(pt, `OFS_STAMP_STATUS), 32'h2000, `RESP_OKAY);
         end else begin
            bus_read(ix(pt, `OFS_DREQ_HIGH), {16'h0, t[31:16]}, `RESP_OKAY);
            bus_read(ix(pt, `OFS_DREQ_LOW), {16'h0, t[15:0]}, `RESP_OKAY);
            bus_read(ix(pt, `OFS_STAMP_STATUS), 32'h4000, `RESP_OKAY);
         end
         bus_write(ix(pt, `OFS_STAMP_STATUS), 32'he000, 4'h2, `RESP_OKAY);
         bus_read(ix(pt, `OFS_STAMP_STATUS), 32'h0, `RESP_OKAY);
      end
      capture(0, 0, 32'h1234_5678);
      bus_read(ix(1, `OFS_STAMP_STATUS), 32'h0, `RESP_OKAY);
      $display("test stamps finished");
      // Signed asymmetry added on sync and response kinds, subtracted on the request kinds
      for (int j = 0; j < 2; j++) begin
         pt = 1 + ($unsigned($random(seed)) % 7);
         asym = {j[0], 15'($random(seed))};
         sv = asym[15] ? -{2'b00, asym[14:0]} : {2'b00, asym[14:0]};
         bus_write(ix(pt, `OFS_ASYMMETRY), asym, 4'h3, `RESP_OKAY);
         bus_read(ix(pt, `OFS_ASYMMETRY), {16'h0, asym}, `RESP_OKAY);
         for (int k = 0; k < 4; k++)
            correct(pt, k, (k == 0 || k == 3) ? sv : -sv);
      end
      correct(0, 0, 17'h0);
      bus_write(ix(1, `OFS_ASYMMETRY), 32'h0005, 4'h3, `RESP_OKAY);
      correct(1, 1, 17'h1fffb);
      bus_write(ix(1, `OFS_ASYMMETRY), 32'h8003, 4'h3, `RESP_OKAY);
      correct(1, 0, 17'h1fffd);
      $display("test correction finished");
      // Unmapped places and out-of-range port nibbles refused
      bus_read(ix(1, 12'hc06), 32'h0, `RESP_SLVERR);
      bus_write(ix(0, `OFS_RX_LATENCY), 32'h1111, 4'h3, `RESP_SLVERR);
      bus_read(ix(8, `OFS_RX_LATENCY), 32'h0, `RESP_SLVERR);
      bus_read(ix(0, `OFS_TREE_STATE), 32'h0, `RESP_SLVERR);
      $display("test unmapped finished");
      repeat (4) @(posedge ref_clk);
      if (bus_q.size() != 0 || corr_q.size() != 0) miscompares++;
      wrap_up;
   end
endmodule
